// File: design/npe_pkg.sv
// Constants, register map and types for the program memory control block.
// Assumes a 25 MHz core clock and a 32-bit Avalon-MM register port.
package npe_pkg;
    localparam int NPE_AW = 5;
    localparam int NPE_DW = 32;
    localparam logic [4:0] NPE_OFF_CTRL = 5'h00;
    localparam logic [4:0] NPE_OFF_ADDR = 5'h04;
    localparam logic [4:0] NPE_OFF_DATA = 5'h08;
    localparam logic [4:0] NPE_OFF_KEY = 5'h0c;
    localparam logic [4:0] NPE_OFF_IRQ_STAT = 5'h10;
    localparam logic [4:0] NPE_OFF_IRQ_CLR = 5'h14;
    localparam logic [4:0] NPE_OFF_IRQ_EN = 5'h18;
    localparam logic [4:0] NPE_OFF_WPROT = 5'h1c;
    // Field positions inside nonvolatile_control_primary.
    localparam int NPE_B_RD = 0;
    localparam int NPE_B_WR = 1;
    localparam int NPE_B_WRITE_ENABLE_BIT = 2;
    localparam int NPE_B_ERR = 3;
    localparam int NPE_B_ERASE = 4;
    localparam int NPE_B_LATCH = 5;
    localparam int NPE_B_SPACE = 6;
    // Event bits of the interrupt status, enable and clear registers.
    localparam int NPE_EV_DONE = 0;
    localparam int NPE_EV_ERR = 1;
    localparam int NPE_EV_RD = 2;
    localparam int NPE_EV_N = 3;
    localparam int NPE_MA_W = 11;
    localparam int NPE_MD_W = 14;
    localparam int NPE_ROW_W = 5;
    localparam int NPE_ROW_WORDS = 32;
    localparam int NPE_MEM_WORDS = 2048;
    localparam logic [7:0] NPE_KEY1 = 8'h55;
    localparam logic [7:0] NPE_KEY2 = 8'haa;
    localparam logic [NPE_MA_W-1:0] NPE_WPROT_RST = 11'h000;
    localparam int NPE_CLK_NS = 40;
    localparam int NPE_PROG_NS = 2000;
    localparam int NPE_ERASE_NS = 2000;
    localparam int NPE_CNT_W = 8;
    localparam int NPE_PROG_CYC = (NPE_PROG_NS + NPE_CLK_NS - 1) / NPE_CLK_NS;
    localparam int NPE_ERASE_CYC = (NPE_ERASE_NS + NPE_CLK_NS - 1) / NPE_CLK_NS;
    localparam int NPE_SHORT_CYC = 1;
    typedef enum logic [1:0] {NPE_OP_READ, NPE_OP_LOAD, NPE_OP_PROG, NPE_OP_ERASE} npe_op_t;
endpackage : npe_pkg

// File: design/npe_core_if.sv
// Carrier between the register front end and the memory sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface npe_core_if;
    logic start;
    npe_pkg::npe_op_t op;
    logic [npe_pkg::NPE_MA_W-1:0] addr;
    logic [npe_pkg::NPE_MD_W-1:0] wdata;
    logic busy;
    logic done;
    logic rvalid;
    logic [npe_pkg::NPE_MD_W-1:0] rdata;
    modport ctl(output start, op, addr, wdata, input busy, done, rvalid, rdata);
    modport core(input start, op, addr, wdata, output busy, done, rvalid, rdata);
endinterface : npe_core_if

// File: design/npe_nvm_core.sv
// Self-timed memory sequencer with the row write latches and the array.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/10ps
module npe_nvm_core (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    npe_core_if.core bus
);
    typedef struct packed {
        logic busy;
        npe_pkg::npe_op_t op;
        logic [npe_pkg::NPE_CNT_W-1:0] cnt;
        logic [npe_pkg::NPE_MA_W-1:0] addr;
        logic [npe_pkg::NPE_MD_W-1:0] wdata;
        logic done;
        logic rvalid;
        logic [npe_pkg::NPE_MD_W-1:0] rdata;
    } npe_core_t;

    npe_core_t s;
    npe_core_t next_s;
    logic [npe_pkg::NPE_MD_W-1:0] mem [npe_pkg::NPE_MEM_WORDS];
    logic [npe_pkg::NPE_MD_W-1:0] wlatch [npe_pkg::NPE_ROW_WORDS];
    logic finish;
    logic [npe_pkg::NPE_MA_W-npe_pkg::NPE_ROW_W-1:0] row;

    assign finish = s.busy && (s.cnt == npe_pkg::NPE_CNT_W'(npe_pkg::NPE_SHORT_CYC));
    assign row = s.addr[npe_pkg::NPE_MA_W-1:npe_pkg::NPE_ROW_W];

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.rvalid = 1'b0;
        if (!reset_n) begin
            next_s = '0;
        end else if (!s.busy && bus.start) begin
            next_s.busy = 1'b1;
            next_s.op = bus.op;
            next_s.addr = bus.addr;
            next_s.wdata = bus.wdata;
            case (bus.op)
                npe_pkg::NPE_OP_PROG: next_s.cnt = npe_pkg::NPE_CNT_W'(npe_pkg::NPE_PROG_CYC);
                npe_pkg::NPE_OP_ERASE: next_s.cnt = npe_pkg::NPE_CNT_W'(npe_pkg::NPE_ERASE_CYC);
                default: next_s.cnt = npe_pkg::NPE_CNT_W'(npe_pkg::NPE_SHORT_CYC);
            endcase
        end else if (finish) begin
            next_s.busy = 1'b0;
            next_s.cnt = '0;
            next_s.done = (s.op != npe_pkg::NPE_OP_READ);
            next_s.rvalid = (s.op == npe_pkg::NPE_OP_READ);
            next_s.rdata = mem[s.addr];
        end else if (s.busy) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (ce) begin
            s <= next_s;
        end
    end

    // The array itself is not reset; only the latches return to the erased value.
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (!reset_n) begin
                for (int i = 0; i < npe_pkg::NPE_ROW_WORDS; i++) begin
                    wlatch[i] <= '1;
                end
            end else if (finish) begin
                case (s.op)
                    npe_pkg::NPE_OP_LOAD: wlatch[s.addr[npe_pkg::NPE_ROW_W-1:0]] <= s.wdata;
                    npe_pkg::NPE_OP_PROG: begin
                        for (int i = 0; i < npe_pkg::NPE_ROW_WORDS; i++) begin
                            if (npe_pkg::NPE_ROW_W'(i) == s.addr[npe_pkg::NPE_ROW_W-1:0]) begin
                                mem[{row, npe_pkg::NPE_ROW_W'(i)}] <= s.wdata;
                            end else begin
                                mem[{row, npe_pkg::NPE_ROW_W'(i)}] <= wlatch[i];
                            end
                            wlatch[i] <= '1;
                        end
                    end
                    npe_pkg::NPE_OP_ERASE: begin
                        for (int i = 0; i < npe_pkg::NPE_ROW_WORDS; i++) begin
                            mem[{row, npe_pkg::NPE_ROW_W'(i)}] <= '1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign bus.busy = s.busy;
    assign bus.done = s.done;
    assign bus.rvalid = s.rvalid;
    assign bus.rdata = s.rdata;
endmodule : npe_nvm_core

// File: design/npe_nvm_ctrl.sv
// Register front end and control of program memory read, write and erase.
// Assumes an Avalon-MM master on mclk and reset inputs already synchronous to mclk.
`timescale 1ns/10ps
module npe_nvm_ctrl (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic por_n,
    input wire logic ce,
    input wire logic [npe_pkg::NPE_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [npe_pkg::NPE_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [npe_pkg::NPE_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    typedef struct packed {
        logic ack;
        logic [npe_pkg::NPE_DW-1:0] rdata;
        logic space;
        logic latch_only;
        logic erase;
        logic err;
        logic write_enable_bit;
        logic wr;
        logic rd;
        logic armed;
        logic key_half;
        logic [npe_pkg::NPE_MA_W-1:0] maddr;
        logic [npe_pkg::NPE_MD_W-1:0] mdata;
        logic [npe_pkg::NPE_MA_W-1:0] wprot;
        logic [npe_pkg::NPE_EV_N-1:0] ev_stat;
        logic [npe_pkg::NPE_EV_N-1:0] ev_en;
        logic start;
        npe_pkg::npe_op_t op;
        logic irq;
    } npe_ctrl_t;

    localparam int WR_BOUND = npe_pkg::NPE_PROG_CYC + npe_pkg::NPE_ERASE_CYC + 3;

    npe_ctrl_t s;
    npe_ctrl_t next_s;
    npe_core_if core_bus ();
    logic req;
    logic acc;
    logic [npe_pkg::NPE_DW-1:0] wd;
    logic [npe_pkg::NPE_DW-1:0] ctl_rd;
    logic [npe_pkg::NPE_EV_N-1:0] ev;
    logic prot_hit;
    logic sw_err_clr;

    // Merges the enabled byte lanes of a write over the old register value.
    function automatic logic [npe_pkg::NPE_DW-1:0] npe_merge(
        input logic [npe_pkg::NPE_DW-1:0] old_v,
        input logic [npe_pkg::NPE_DW-1:0] new_v,
        input logic [3:0] be
    );
        logic [npe_pkg::NPE_DW-1:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : npe_merge

    npe_nvm_core npe_nvm_core_inst (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .bus(core_bus)
    );

    assign req = avs_read | avs_write;
    assign acc = req & s.ack;

    always_comb begin
        ctl_rd = '0;
        ctl_rd[npe_pkg::NPE_B_RD] = s.rd;
        ctl_rd[npe_pkg::NPE_B_WR] = s.wr;
        ctl_rd[npe_pkg::NPE_B_WRITE_ENABLE_BIT] = s.write_enable_bit;
        // The flag is read back as stored even while a write runs; it is only settled after.
        ctl_rd[npe_pkg::NPE_B_ERR] = s.err;
        ctl_rd[npe_pkg::NPE_B_ERASE] = s.erase;
        ctl_rd[npe_pkg::NPE_B_LATCH] = s.latch_only;
        ctl_rd[npe_pkg::NPE_B_SPACE] = s.space;
    end

    always_comb begin
        next_s = s;
        wd = '0;
        ev = '0;
        prot_hit = 1'b0;
        sw_err_clr = 1'b0;
        next_s.start = 1'b0;
        next_s.ack = req & !s.ack;
        if (next_s.ack && avs_read) begin
            case (avs_address)
                npe_pkg::NPE_OFF_CTRL: next_s.rdata = ctl_rd;
                npe_pkg::NPE_OFF_ADDR: next_s.rdata = npe_pkg::NPE_DW'(s.maddr);
                npe_pkg::NPE_OFF_DATA: next_s.rdata = npe_pkg::NPE_DW'(s.mdata);
                npe_pkg::NPE_OFF_IRQ_STAT: next_s.rdata = npe_pkg::NPE_DW'(s.ev_stat);
                npe_pkg::NPE_OFF_IRQ_EN: next_s.rdata = npe_pkg::NPE_DW'(s.ev_en);
                npe_pkg::NPE_OFF_WPROT: next_s.rdata = npe_pkg::NPE_DW'(s.wprot);
                default: next_s.rdata = '0;
            endcase
        end
        // Any access between the two key writes breaks the unlock sequence.
        if (acc && s.key_half && !(avs_write && avs_address == npe_pkg::NPE_OFF_KEY)) begin
            next_s.key_half = 1'b0;
            ev[npe_pkg::NPE_EV_ERR] = 1'b1;
        end
        if (acc && avs_write) begin
            case (avs_address)
                npe_pkg::NPE_OFF_CTRL: begin
                    wd = npe_merge(ctl_rd, avs_writedata, avs_byteenable);
                    next_s.armed = 1'b0;
                    next_s.space = wd[npe_pkg::NPE_B_SPACE];
                    next_s.latch_only = wd[npe_pkg::NPE_B_LATCH];
                    next_s.erase = wd[npe_pkg::NPE_B_ERASE];
                    next_s.write_enable_bit = wd[npe_pkg::NPE_B_WRITE_ENABLE_BIT];
                    if (wd[npe_pkg::NPE_B_ERR]) begin
                        next_s.err = 1'b1;
                    end else begin
                        sw_err_clr = 1'b1;
                        next_s.err = 1'b0;
                    end
                    if (wd[npe_pkg::NPE_B_RD] && !s.rd && !s.wr) begin
                        next_s.rd = 1'b1;
                        next_s.start = 1'b1;
                        next_s.op = npe_pkg::NPE_OP_READ;
                    end
                    // A written 0 on a running strobe falls through untouched.
                    if (wd[npe_pkg::NPE_B_WR] && !s.wr && !s.rd && s.armed) begin
                        if (next_s.write_enable_bit && !next_s.space) begin
                            if (s.maddr < s.wprot) begin
                                prot_hit = 1'b1;
                                ev[npe_pkg::NPE_EV_ERR] = 1'b1;
                            end else begin
                                next_s.wr = 1'b1;
                                next_s.start = 1'b1;
                                if (next_s.erase) begin
                                    next_s.op = npe_pkg::NPE_OP_ERASE;
                                end else if (next_s.latch_only) begin
                                    next_s.op = npe_pkg::NPE_OP_LOAD;
                                end else begin
                                    next_s.op = npe_pkg::NPE_OP_PROG;
                                end
                            end
                        end
                    end
                end
                npe_pkg::NPE_OFF_ADDR: begin
                    wd = npe_merge(npe_pkg::NPE_DW'(s.maddr), avs_writedata, avs_byteenable);
                    if (!s.wr && !s.rd) begin
                        next_s.maddr = wd[npe_pkg::NPE_MA_W-1:0];
                    end
                end
                npe_pkg::NPE_OFF_DATA: begin
                    wd = npe_merge(npe_pkg::NPE_DW'(s.mdata), avs_writedata, avs_byteenable);
                    if (!s.wr && !s.rd) begin
                        next_s.mdata = wd[npe_pkg::NPE_MD_W-1:0];
                    end
                end
                npe_pkg::NPE_OFF_KEY: begin
                    wd = npe_merge('0, avs_writedata, avs_byteenable);
                    next_s.armed = 1'b0;
                    next_s.key_half = 1'b0;
                    if (wd[7:0] == npe_pkg::NPE_KEY1) begin
                        next_s.key_half = 1'b1;
                    end else if (s.key_half && wd[7:0] == npe_pkg::NPE_KEY2) begin
                        next_s.armed = 1'b1;
                    end else if (s.key_half) begin
                        ev[npe_pkg::NPE_EV_ERR] = 1'b1;
                    end
                end
                npe_pkg::NPE_OFF_IRQ_CLR: begin
                    wd = npe_merge('0, avs_writedata, avs_byteenable);
                    next_s.ev_stat = s.ev_stat & ~wd[npe_pkg::NPE_EV_N-1:0];
                end
                npe_pkg::NPE_OFF_IRQ_EN: begin
                    wd = npe_merge(npe_pkg::NPE_DW'(s.ev_en), avs_writedata, avs_byteenable);
                    next_s.ev_en = wd[npe_pkg::NPE_EV_N-1:0];
                end
                npe_pkg::NPE_OFF_WPROT: begin
                    wd = npe_merge(npe_pkg::NPE_DW'(s.wprot), avs_writedata, avs_byteenable);
                    next_s.wprot = wd[npe_pkg::NPE_MA_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (core_bus.done) begin
            next_s.wr = 1'b0;
            ev[npe_pkg::NPE_EV_DONE] = 1'b1;
        end
        if (core_bus.rvalid) begin
            next_s.rd = 1'b0;
            next_s.mdata = core_bus.rdata;
            ev[npe_pkg::NPE_EV_RD] = 1'b1;
        end
        // Hardware events are applied last so that a set beats a clear in the same cycle.
        if (ev[npe_pkg::NPE_EV_ERR]) begin
            next_s.err = 1'b1;
        end
        next_s.ev_stat = next_s.ev_stat | ev;
        if (!reset_n) begin
            next_s = '0;
            next_s.wprot = npe_pkg::NPE_WPROT_RST;
            // A plain reset keeps the flag and flags a write that it cuts short.
            next_s.err = por_n & (s.err | s.wr);
        end
        next_s.irq = |(next_s.ev_stat & next_s.ev_en);
    end

    always_ff @(posedge mclk) begin
        if (ce) begin
            s <= next_s;
        end
    end

    assign core_bus.start = s.start;
    assign core_bus.op = s.op;
    assign core_bus.addr = s.maddr;
    assign core_bus.wdata = s.mdata;
    assign avs_waitrequest = req & !s.ack;
    assign avs_readdata = s.rdata;
    assign irq = s.irq;

    sequence s_start_seen;
        s.start && s.wr;
    endsequence

    sequence s_wr_rise;
        $rose(s.wr);
    endsequence

    property p_latch_load;
        @(posedge mclk) disable iff (!reset_n || !ce)
        (s_start_seen and (!s.erase && s.latch_only)) |-> s.op == npe_pkg::NPE_OP_LOAD;
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latch-only write started a memory op");

    property p_prog;
        @(posedge mclk) disable iff (!reset_n || !ce)
        (s_start_seen and (!s.erase && !s.latch_only)) |-> s.op == npe_pkg::NPE_OP_PROG;
    endproperty
    a_prog: assert property (p_prog) else $error("write without latch-only did not program");

    property p_erase;
        @(posedge mclk) disable iff (!reset_n || !ce)
        (s_start_seen and s.erase) |-> s.op == npe_pkg::NPE_OP_ERASE;
    endproperty
    a_erase: assert property (p_erase) else $error("erase mode did not start an erase");

    property p_write_enable_bit_gate;
        @(posedge mclk) disable iff (!reset_n || !ce)
        s_start_seen |-> s.write_enable_bit && !s.space;
    endproperty
    a_write_enable_bit_gate: assert property (p_write_enable_bit_gate) else $error("program cycle started with enable clear");

    property p_prot_err;
        @(posedge mclk) disable iff (!reset_n || !ce)
        prot_hit |=> s.err && !s.wr;
    endproperty
    a_prot_err: assert property (p_prot_err) else $error("protected target did not raise error");

    property p_err_sticky;
        @(posedge mclk) disable iff (!reset_n || !ce)
        s.err && !sw_err_clr |=> s.err;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag cleared by hardware");

    property p_wr_done;
        @(posedge mclk) disable iff (!reset_n || !ce)
        s_wr_rise |-> ##1 core_bus.busy ##[1:WR_BOUND] !s.wr;
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("write strobe did not complete in time");

    property p_wr_hold;
        @(posedge mclk) disable iff (!reset_n || !ce)
        s.wr && !core_bus.done |=> s.wr;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("running write strobe dropped early");

    property p_rd_done;
        @(posedge mclk) disable iff (!reset_n || !ce)
        $rose(s.rd) |-> s.rd [*3] ##1 (!s.rd && s.mdata == $past(core_bus.rdata));
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read strobe did not load data in 3 cycles");

    property p_rd_hold;
        @(posedge mclk) disable iff (!reset_n || !ce)
        s.rd && !core_bus.rvalid |=> s.rd;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read strobe cleared before data came");

    property p_rd_idle;
        @(posedge mclk) disable iff (!reset_n || !ce)
        !s.rd && !s.start |=> !core_bus.busy || s.wr;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read path busy while strobe reads 0");
endmodule : npe_nvm_ctrl

// File: dv/nvm_program_erase_control_tb.sv
// Self-checking bench for the program memory control block, driven over Avalon-MM.
// Assumes the design answers each access after one wait state and holds assertions itself.
`timescale 1ns/10ps
module nvm_program_erase_control_tb;
    localparam logic [31:0] RD = 32'h01, WR = 32'h02, WEN = 32'h04, ERR = 32'h08;
    localparam logic [31:0] ERS = 32'h10, LAT = 32'h20;
    localparam logic [10:0] ROW = 11'h040;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic por_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic [31:0] q;
    int n_errors = 0;
    int num_checks = 0;

    npe_nvm_ctrl npe_nvm_ctrl_inst (.mclk(mclk), .reset_n(reset_n), .por_n(por_n), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));

    always #20 mclk = ~mclk;

    task complete_run;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk

    // The request is held until the rising edge at which waitrequest is sampled low.
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        bit ok;
        ok = 1'b0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge mclk);
            ok = (avs_waitrequest === 1'b0);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
        if (!ok) begin
            n_errors++;
            $display("[FAIL] %0t bus access never answered", $time);
            complete_run();
        end
    endtask : bus

    task rd_reg(input logic [4:0] a, input logic [31:0] exp, input string m);
        bus(1'b0, a, 32'h0);
        chk(q, exp, m);
    endtask : rd_reg

    // The error flag is not looked at here, since it means nothing while a strobe runs.
    task poll(input logic [31:0] m);
        for (int i = 0; i < 40; i++) begin
            bus(1'b0, npe_pkg::NPE_OFF_CTRL, 32'h0);
            if ((q & m) === 32'h0) return;
        end
        n_errors++;
        $display("[FAIL] %0t strobe never cleared", $time);
        complete_run();
    endtask : poll

    task unlock;
        bus(1'b1, npe_pkg::NPE_OFF_KEY, {24'h0, npe_pkg::NPE_KEY1});
        bus(1'b1, npe_pkg::NPE_OFF_KEY, {24'h0, npe_pkg::NPE_KEY2});
    endtask : unlock

    task op(input logic [10:0] a, input logic [13:0] d, input logic [31:0] c);
        bus(1'b1, npe_pkg::NPE_OFF_ADDR, {21'h0, a});
        bus(1'b1, npe_pkg::NPE_OFF_DATA, {18'h0, d});
        unlock();
        bus(1'b1, npe_pkg::NPE_OFF_CTRL, c | WR | WEN);
        poll(WR);
    endtask : op

    task rdmem(input logic [10:0] a, input logic [13:0] exp);
        bus(1'b1, npe_pkg::NPE_OFF_ADDR, {21'h0, a});
        bus(1'b1, npe_pkg::NPE_OFF_CTRL, RD);
        poll(RD);
        rd_reg(npe_pkg::NPE_OFF_DATA, {18'h0, exp}, "memory word");
    endtask : rdmem

    task irq_is(input logic exp);
        @(negedge mclk);
        chk({31'h0, irq}, {31'h0, exp}, "irq level");
        @(posedge mclk);
    endtask : irq_is

    task t_reset;
        rd_reg(npe_pkg::NPE_OFF_CTRL, 32'h0, "control after reset");
        rd_reg(npe_pkg::NPE_OFF_IRQ_STAT, 32'h0, "status after reset");
        rd_reg(npe_pkg::NPE_OFF_WPROT, 32'h0, "limit after reset");
        irq_is(1'b0);
    endtask : t_reset

    task t_refused;
        bus(1'b1, npe_pkg::NPE_OFF_CTRL, WR | WEN);
        rd_reg(npe_pkg::NPE_OFF_CTRL, WEN, "strobe without unlock");
        unlock();
        bus(1'b1, npe_pkg::NPE_OFF_CTRL, WR);
        rd_reg(npe_pkg::NPE_OFF_CTRL, 32'h0, "strobe with enable clear");
        rd_reg(npe_pkg::NPE_OFF_IRQ_STAT, 32'h0, "no operation ran");
    endtask : t_refused

    task t_erase_program;
        op(ROW + 11'h5, 14'h0, ERS | LAT);
        rdmem(ROW, 14'h3fff);
        rdmem(ROW + 11'h1f, 14'h3fff);
        bus(1'b1, npe_pkg::NPE_OFF_ADDR, {21'h0, ROW + 11'h2});
        bus(1'b1, npe_pkg::NPE_OFF_DATA, 32'h1234);
        unlock();
        bus(1'b1, npe_pkg::NPE_OFF_CTRL, WR | WEN);
        bus(1'b0, npe_pkg::NPE_OFF_CTRL, 32'h0);
        chk(q & ~ERR, WR | WEN, "strobe running");
        bus(1'b1, npe_pkg::NPE_OFF_CTRL, WEN);
        bus(1'b0, npe_pkg::NPE_OFF_CTRL, 32'h0);
        chk(q & WR, WR, "strobe kept after write of 0");
        poll(WR);
        rd_reg(npe_pkg::NPE_OFF_CTRL, WEN, "strobe done, no error");
        rdmem(ROW + 11'h2, 14'h1234);
        rdmem(ROW + 11'h3, 14'h3fff);
    endtask : t_erase_program

    task t_latch;
        op(ROW + 11'h7, 14'h0abc, LAT);
        rdmem(ROW + 11'h7, 14'h3fff);
        op(ROW + 11'h8, 14'h0123, 32'h0);
        rdmem(ROW + 11'h7, 14'h0abc);
        rdmem(ROW + 11'h8, 14'h0123);
        rd_reg(npe_pkg::NPE_OFF_CTRL, 32'h0, "read strobe idle");
    endtask : t_latch

    task t_errors;
        bus(1'b1, npe_pkg::NPE_OFF_IRQ_CLR, 32'h7);
        bus(1'b1, npe_pkg::NPE_OFF_IRQ_EN, 32'h2);
        bus(1'b1, npe_pkg::NPE_OFF_WPROT, 32'h100);
        op(11'h0f0, 14'h1, 32'h0);
        rd_reg(npe_pkg::NPE_OFF_CTRL, WEN | ERR, "protected target");
        bus(1'b0, npe_pkg::NPE_OFF_IRQ_STAT, 32'h0);
        chk(q & 32'h3, 32'h2, "error event only");
        irq_is(1'b1);
        bus(1'b1, npe_pkg::NPE_OFF_IRQ_CLR, 32'h2);
        irq_is(1'b0);
        bus(1'b1, npe_pkg::NPE_OFF_CTRL, 32'h0);
        rd_reg(npe_pkg::NPE_OFF_CTRL, 32'h0, "software clears error");
        bus(1'b1, npe_pkg::NPE_OFF_CTRL, ERR);
        rd_reg(npe_pkg::NPE_OFF_CTRL, ERR, "software sets error");
        bus(1'b1, npe_pkg::NPE_OFF_CTRL, 32'h0);
        bus(1'b1, npe_pkg::NPE_OFF_WPROT, 32'h0);
        bus(1'b1, npe_pkg::NPE_OFF_IRQ_EN, 32'h0);
        bus(1'b1, npe_pkg::NPE_OFF_KEY, {24'h0, npe_pkg::NPE_KEY1});
        bus(1'b0, npe_pkg::NPE_OFF_IRQ_STAT, 32'h0);
        rd_reg(npe_pkg::NPE_OFF_CTRL, ERR, "broken unlock");
        irq_is(1'b0);
        bus(1'b1, npe_pkg::NPE_OFF_IRQ_EN, 32'h2);
        irq_is(1'b1);
        bus(1'b1, npe_pkg::NPE_OFF_IRQ_CLR, 32'h2);
        irq_is(1'b0);
    endtask : t_errors

    // A plain reset that cuts a running program leaves the flag set; power-on clears it.
    task t_reset_cut;
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, npe_pkg::NPE_OFF_ADDR, {21'h0, ROW + 11'h9});
            unlock();
            bus(1'b1, npe_pkg::NPE_OFF_CTRL, WR | WEN);
            reset_n <= 1'b0;
            por_n <= (k == 0);
            repeat (2) @(posedge mclk);
            reset_n <= 1'b1;
            por_n <= 1'b1;
            @(posedge mclk);
            rd_reg(npe_pkg::NPE_OFF_CTRL, (k == 0) ? ERR : 32'h0, "flag after cut write");
        end
    endtask : t_reset_cut

    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        por_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_refused();
        t_erase_program();
        t_latch();
        t_errors();
        t_reset_cut();
        complete_run();
    end
endmodule : nvm_program_erase_control_tb
